// ### design/mqs_pkg.sv
// Shared constants of the multi-queue select and flag block.
package mqs_pkg;

   // Data path and queue geometry.
   localparam int DATA_W = 18;
   localparam int QUEUES = 8;
   localparam int DEPTH  = 16;
   localparam int DEV_W  = 3;

   // APB register byte addresses.
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LEVEL  = 8'h08;

   // Control register fields.
   localparam int          CTRL_AF_LSB   = 0;
   localparam int          CTRL_LVL_LSB  = 16;
   localparam logic [7:0]  AF_OFF_RESET  = 8'h02;

   // Status register fields.
   localparam int ST_OWN_DONE  = 0;
   localparam int ST_CHAIN_OK  = 1;
   localparam int ST_WQ_LSB    = 4;
   localparam int ST_RQ_LSB    = 8;
   localparam int ST_RNULL     = 12;
   localparam int ST_FULL_N    = 16;
   localparam int ST_OV_N      = 17;
   localparam int ST_AF_N      = 18;

   // Loading count at which default configuration loading ends after reset.
   localparam logic [4:0] PROG_CYCLES = 5'h10;

   // Queue selection pipeline: three stages, taps counted from zero.
   localparam int SEL_STAGES = 3;
   localparam int WR_OE_TAP  = 0;
   localparam int WR_TGT_TAP = 1;
   localparam int RD_TGT_TAP = 1;

   // Read-side switch countdown values.
   localparam logic [1:0] SW_LOAD     = 2'h3;
   localparam logic [1:0] SW_INFLIGHT = 2'h2;
   localparam logic [1:0] SW_FALL     = 2'h1;

   // Programming state.
   typedef enum logic {PRG_LOAD, PRG_DONE} mqs_prog_e;

endpackage

// ### design/mqs_sel_delay.sv
`timescale 1ns/1ps
// Shift pipeline that delays a queue selection and exposes every stage.
module mqs_sel_delay
   import mqs_pkg::*;
#(
   parameter int W      = 5,
   parameter int STAGES = 3
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire logic [W-1:0]          i_d,
   output logic      [STAGES*W-1:0]   o_taps
);

   logic [STAGES*W-1:0] taps;
   logic [STAGES*W-1:0] next_taps;

   // Stage zero takes the input, each further stage the one before.
   generate
      if (STAGES > 1) begin : g_multi
         assign next_taps = {taps[(STAGES-1)*W-1:0], i_d};
      end else begin : g_single
         assign next_taps = i_d;
      end
   endgenerate

   assign o_taps = taps;

   // Stages clear to an unselected code so no flag drives out of reset.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         taps <= '0;
      end else begin
         taps <= next_taps;
      end
   end

endmodule

// ### design/mqs_qptr.sv
`timescale 1ns/1ps
// Write pointer, read pointer and occupancy of one queue.
module mqs_qptr
   import mqs_pkg::*;
#(
   parameter int DEPTH_P = 16,
   parameter int AW      = 4
) (
   input  wire logic          i_clk,
   input  wire logic          i_nrst,
   input  wire logic          i_push,
   input  wire logic          i_pop,
   output logic      [AW-1:0] o_wptr,
   output logic      [AW-1:0] o_rptr,
   output logic      [AW:0]   o_count
);

   logic [AW:0] next_count;

   // The caller never pushes a full or pops an empty queue.
   assign next_count = o_count + {{AW{1'b0}}, i_push} - {{AW{1'b0}}, i_pop};

   // Pointers wrap naturally since the depth is a power of two.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wptr  <= '0;
         o_rptr  <= '0;
         o_count <= '0;
      end else begin
         o_wptr  <= o_wptr + AW'(i_push);
         o_rptr  <= o_rptr + AW'(i_pop);
         o_count <= next_count;
      end
   end

endmodule

// ### design/mqs_core.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////
module mqs_core
   import mqs_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int NQ = QUEUES,
   parameter int ND = DEPTH
) (
   input  wire logic              I_CLK,
   input  wire logic              I_NRST,
   input  wire logic              I_PSEL,
   input  wire logic              I_PENABLE,
   input  wire logic              I_PWRITE,
   input  wire logic [7:0]        I_PADDR,
   input  wire logic [31:0]       I_PWDATA,
   output logic      [31:0]       O_PRDATA,
   output logic                   O_PREADY,
   output logic                   O_PSLVERR,
   input  wire logic [DEV_W-1:0]  I_DEVICE_SELECT_CODE,
   input  wire logic              I_SERIAL_ENABLE_IN_N,
   output logic                   O_PROGRAMMING_DONE_OUT_N,
   input  wire logic              I_WR_QSEL,
   input  wire logic [DEV_W-1:0]  I_WR_QDEV,
   input  wire logic [2:0]        I_WR_QNUM,
   input  wire logic              I_WEN_N,
   input  wire logic [DW-1:0]     I_WDATA,
   output logic                   O_QUEUE_FULL_N,
   output logic                   O_QUEUE_FULL_N_OE,
   output logic                   O_ALMOST_FULL_N,
   output logic                   O_ALMOST_FULL_N_OE,
   input  wire logic              I_RD_QSEL,
   input  wire logic [DEV_W-1:0]  I_RD_QDEV,
   input  wire logic [2:0]        I_RD_QNUM,
   input  wire logic              I_RD_NULL,
   input  wire logic              I_REN_N,
   input  wire logic              I_OE_N,
   output logic      [DW-1:0]     O_RDATA,
   output logic                   O_RDATA_OE,
   output logic                   O_OUTPUT_VALID_N,
   output logic                   O_OUTPUT_VALID_N_OE
);

   localparam int AW = $clog2(ND);
   localparam int QW = 3;
   localparam int WSW = QW + 1;
   localparam int RSW = QW + 2;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Default programming.

   mqs_prog_e   prog_state;
   mqs_prog_e   next_prog_state;
   logic [4:0]  prog_cnt;
   logic        own_done;
   logic        ops_ok;

   // Loading counts on the system clock alone, so a serial clock pin is never needed.
   always_comb begin
      next_prog_state = prog_state;
      case (prog_state)
         PRG_LOAD: begin
            if (prog_cnt == PROG_CYCLES) begin
               next_prog_state = PRG_DONE;
            end
         end
         PRG_DONE: next_prog_state = PRG_DONE;
         default:  next_prog_state = PRG_LOAD;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         prog_state <= PRG_LOAD;
         prog_cnt   <= '0;
      end else begin
         prog_state <= next_prog_state;
         prog_cnt   <= (prog_state == PRG_LOAD) ? prog_cnt + 5'h01 : prog_cnt;
      end
   end

   // The chain input passes through only once this device has finished loading.
   assign own_done = (prog_state == PRG_DONE);
   assign ops_ok   = own_done && !I_SERIAL_ENABLE_IN_N;

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_PROGRAMMING_DONE_OUT_N <= 1'b1;
      end else begin
         O_PROGRAMMING_DONE_OUT_N <= !ops_ok;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Per-queue pointers and storage.

   logic [AW-1:0] q_wptr  [NQ];
   logic [AW-1:0] q_rptr  [NQ];
   logic [AW:0]   q_count [NQ];
   logic [NQ-1:0] q_push;
   logic [NQ-1:0] q_pop;
   logic [DW-1:0] mem [NQ*ND];

   generate
      for (genvar g = 0; g < NQ; g++) begin : g_q
         mqs_qptr #(
            .DEPTH_P (ND),
            .AW      (AW)
         ) u_ptr (
            .i_clk   (I_CLK),
            .i_nrst  (I_NRST),
            .i_push  (q_push[g]),
            .i_pop   (q_pop[g]),
            .o_wptr  (q_wptr[g]),
            .o_rptr  (q_rptr[g]),
            .o_count (q_count[g])
         );
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////////////////
   // Write port selection pipeline.

   logic [WSW-1:0]            wr_sel;
   logic [SEL_STAGES*WSW-1:0] wr_taps;
   logic [WSW-1:0]            wr_tgt;
   logic [WSW-1:0]            wr_oe_sel;
   logic [QW-1:0]             wt_q;
   logic                      wt_here;
   logic                      wt_full;
   logic                      wt_afull;
   logic                      wr_go;
   logic [7:0]                af_off;
   logic [AW:0]               af_level;

   // Select codes are compared to the strap; a single device ties both low.
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         wr_sel <= '0;
      end else if (I_WR_QSEL && ops_ok) begin
         wr_sel <= {(I_WR_QDEV == I_DEVICE_SELECT_CODE), I_WR_QNUM};
      end
   end

   mqs_sel_delay #(
      .W      (WSW),
      .STAGES (SEL_STAGES)
   ) u_wr_delay (
      .i_clk  (I_CLK),
      .i_nrst (I_NRST),
      .i_d    (wr_sel),
      .o_taps (wr_taps)
   );

   // Writes and flags follow the delayed selection, so the old queue lingers.
   assign wr_tgt    = wr_taps[WR_TGT_TAP*WSW +: WSW];
   assign wr_oe_sel = wr_taps[WR_OE_TAP*WSW +: WSW];
   assign wt_q      = wr_tgt[QW-1:0];
   assign wt_here   = wr_tgt[QW];
   assign wt_full   = (q_count[wt_q] == (AW+1)'(ND));
   assign af_level  = (AW+1)'(ND) - (AW+1)'(af_off);
   assign wt_afull  = (q_count[wt_q] >= af_level);
   assign wr_go     = !I_WEN_N && wt_here && !wt_full && ops_ok;

   // Flags are registered, so a read that frees space shows one cycle late.
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_QUEUE_FULL_N  <= 1'b1;
         O_ALMOST_FULL_N <= 1'b1;
      end else begin
         O_QUEUE_FULL_N  <= !(wt_full || (wr_go && q_count[wt_q] == (AW+1)'(ND - 1)));
         O_ALMOST_FULL_N <= !wt_afull;
      end
   end

   // The full flag floats until the new device has held the selection two cycles.
   assign O_QUEUE_FULL_N_OE  = wr_oe_sel[QW] && wt_here;
   assign O_ALMOST_FULL_N_OE = wr_oe_sel[QW] && wt_here;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Read port selection and switch countdown.

   logic [RSW-1:0]            rd_sel;
   logic [SEL_STAGES*RSW-1:0] rd_taps;
   logic [RSW-1:0]            rd_tgt;
   logic [RSW-1:0]            rd_prev;
   logic [1:0]                sw_cnt;
   logic                      same_dev;

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rd_sel <= '0;
         sw_cnt <= '0;
      end else if (I_RD_QSEL && ops_ok) begin
         rd_sel <= {(I_RD_QDEV == I_DEVICE_SELECT_CODE), I_RD_NULL, I_RD_QNUM};
         sw_cnt <= SW_LOAD;
      end else if (sw_cnt != 2'h0) begin
         sw_cnt <= sw_cnt - 2'h1;
      end
   end

   mqs_sel_delay #(
      .W      (RSW),
      .STAGES (SEL_STAGES)
   ) u_rd_delay (
      .i_clk  (I_CLK),
      .i_nrst (I_NRST),
      .i_d    (rd_sel),
      .o_taps (rd_taps)
   );

   assign rd_tgt   = rd_taps[RD_TGT_TAP*RSW +: RSW];
   assign rd_prev  = rd_taps[(RD_TGT_TAP-1)*RSW +: RSW];
   assign same_dev = (rd_prev[RSW-1] == rd_tgt[RSW-1]);

   //////////////////////////////////////////////////////////////////////////////////////////
   // First-word fall-through output stage.

   logic [QW-1:0] rt_q;
   logic          rt_here;
   logic          rt_null;
   logic          rt_empty;
   logic          rd_want;
   logic          rd_adv;
   logic          rd_pop;

   assign rt_q    = rd_tgt[QW-1:0];
   assign rt_null = rd_tgt[QW];
   assign rt_here = rd_tgt[RSW-1];

   // The null queue looks empty, so nothing refills the output pipeline.
   assign rt_empty = rt_null || (q_count[rt_q] == '0);

   // A stale or invalid output is refilled as soon as a word exists.
   assign rd_want = !I_REN_N || O_OUTPUT_VALID_N;

   // During a switch the advance is forced: in-flight words first when same_dev holds, then the new queue.
   always_comb begin
      case (sw_cnt)
         SW_FALL:     rd_adv = 1'b1;
         SW_INFLIGHT: rd_adv = same_dev;
         default:     rd_adv = rd_want;
      endcase
   end

   assign rd_pop = rd_adv && rt_here && !rt_empty && ops_ok;

   // Each queue pushes and pops only through its own pointers.
   always_comb begin
      q_push = '0;
      q_pop  = '0;
      q_push[wt_q] = wr_go;
      q_pop[rt_q]  = rd_pop;
   end

   always_ff @(posedge I_CLK) begin
      if (wr_go) begin
         mem[{wt_q, q_wptr[wt_q]}] <= I_WDATA;
      end
   end

   // Empty queues leave the last word in place and mark it invalid.
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_RDATA          <= '0;
         O_OUTPUT_VALID_N <= 1'b1;
      end else if (rd_pop) begin
         O_RDATA          <= mem[{rt_q, q_rptr[rt_q]}];
         O_OUTPUT_VALID_N <= 1'b0;
      end else if (rd_adv && rt_here) begin
         O_OUTPUT_VALID_N <= 1'b1;
      end
   end

   // Output enable only gates the drivers, so the register keeps its word.
   assign O_RDATA_OE          = rt_here && !I_OE_N;
   assign O_OUTPUT_VALID_N_OE = rt_here;

   //////////////////////////////////////////////////////////////////////////////////////////
   // APB slave.

   logic       bus_setup;
   logic       bus_write;
   logic       hit_ctrl;
   logic       hit_status;
   logic       hit_level;
   logic       hit_any;
   logic [2:0] lvl_q;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic [31:0] level_word;
   logic [31:0] rd_mux;

   assign hit_ctrl   = (I_PADDR == REG_CTRL);
   assign hit_status = (I_PADDR == REG_STATUS);
   assign hit_level  = (I_PADDR == REG_LEVEL);
   assign hit_any    = hit_ctrl || hit_status || hit_level;
   assign bus_setup  = I_PSEL && !I_PENABLE;
   assign bus_write  = I_PSEL && I_PENABLE && I_PWRITE && hit_ctrl;

   // Every access completes at once; unmapped addresses answer with an error.
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !hit_any;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CTRL_AF_LSB +: 8]  = af_off;
      ctrl_word[CTRL_LVL_LSB +: 3] = lvl_q;
   end

   always_comb begin
      status_word = '0;
      status_word[ST_OWN_DONE]       = own_done;
      status_word[ST_CHAIN_OK]       = ops_ok;
      status_word[ST_WQ_LSB +: QW]   = wt_q;
      status_word[ST_RQ_LSB +: QW]   = rt_q;
      status_word[ST_RNULL]          = rt_null;
      status_word[ST_FULL_N]         = O_QUEUE_FULL_N;
      status_word[ST_OV_N]           = O_OUTPUT_VALID_N;
      status_word[ST_AF_N]           = O_ALMOST_FULL_N;
   end

   assign level_word = {{(31-AW){1'b0}}, q_count[lvl_q]};
   assign rd_mux     = hit_ctrl ? ctrl_word : hit_status ? status_word :
                       hit_level ? level_word : 32'h0000_0000;

   // Software sets the almost-full distance and which queue the level register shows.
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         af_off <= AF_OFF_RESET;
         lvl_q  <= '0;
      end else if (bus_write) begin
         af_off <= I_PWDATA[CTRL_AF_LSB +: 8];
         lvl_q  <= I_PWDATA[CTRL_LVL_LSB +: 3];
      end
   end

   // Read data is captured in the setup cycle and stands through the access.
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_PRDATA <= '0;
      end else if (bus_setup && !I_PWRITE) begin
         O_PRDATA <= rd_mux;
      end
   end

endmodule

// ### dv/mqs_core_props.sv
`timescale 1ns/1ps
// Port-level checker of the queue select and flag block.
module mqs_core_props
   import mqs_pkg::*;
#(
   parameter int DW = DATA_W
) (
   input wire logic             I_CLK,
   input wire logic             I_NRST,
   input wire logic [DEV_W-1:0] I_DEVICE_SELECT_CODE,
   input wire logic             I_SERIAL_ENABLE_IN_N,
   input wire logic             O_PROGRAMMING_DONE_OUT_N,
   input wire logic             I_WR_QSEL,
   input wire logic [DEV_W-1:0] I_WR_QDEV,
   input wire logic             I_WEN_N,
   input wire logic             O_QUEUE_FULL_N,
   input wire logic             O_QUEUE_FULL_N_OE,
   input wire logic             I_RD_QSEL,
   input wire logic [DEV_W-1:0] I_RD_QDEV,
   input wire logic             I_REN_N,
   input wire logic             I_OE_N,
   input wire logic [DW-1:0]    O_RDATA,
   input wire logic             O_RDATA_OE,
   input wire logic             O_OUTPUT_VALID_N,
   input wire logic             O_OUTPUT_VALID_N_OE
);
   logic [4:0] cyc;
   logic [1:0] quiet;

   // Edges since reset and since the last read select; both saturate so they never wrap.
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cyc   <= 5'h00;
         quiet <= 2'h0;
      end else begin
         cyc   <= (cyc == 5'h1f) ? cyc : cyc + 5'h01;
         quiet <= I_RD_QSEL ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // All checks share the one clock and the one reset.
   default clocking @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);

   done_early_a: assert property (cyc < 5'h0f |-> O_PROGRAMMING_DONE_OUT_N)
      else $error("loading reported done too early");
   done_late_a: assert property (cyc == 5'h14 && !I_SERIAL_ENABLE_IN_N |-> !O_PROGRAMMING_DONE_OUT_N)
      else $error("loading never reported done");
   full_oe_a: assert property (I_WR_QSEL && I_WR_QDEV == I_DEVICE_SELECT_CODE
      && !O_QUEUE_FULL_N_OE && !O_PROGRAMMING_DONE_OUT_N
      |=> !O_QUEUE_FULL_N_OE ##1 !O_QUEUE_FULL_N_OE ##1 O_QUEUE_FULL_N_OE)
      else $error("full flag drive not two cycles late");
   full_off_a: assert property (I_WR_QSEL && I_WR_QDEV != I_DEVICE_SELECT_CODE
      |-> ##2 !O_QUEUE_FULL_N_OE)
      else $error("deselected device still drives full flag");
   full_fall_a: assert property ($fell(O_QUEUE_FULL_N) |-> !$past(I_WEN_N) || $past(I_WR_QSEL, 4))
      else $error("full flag fell without a write or switch");
   ov_rise_a: assert property ($rose(O_OUTPUT_VALID_N)
      |-> !$past(I_REN_N) || $past(I_RD_QSEL, 3) || $past(I_RD_QSEL, 4))
      else $error("valid flag dropped without an advance");
   hold_a: assert property (I_REN_N && !O_OUTPUT_VALID_N && quiet == 2'h3 |=> $stable(O_RDATA))
      else $error("output word moved without a read");
   oe_gate_a: assert property (I_OE_N |-> !O_RDATA_OE)
      else $error("data bus driven while output disabled");
   drive_pair_a: assert property (O_RDATA_OE |-> O_OUTPUT_VALID_N_OE)
      else $error("data driven without the valid flag");
   rd_off_a: assert property (I_RD_QSEL && I_RD_QDEV != I_DEVICE_SELECT_CODE
      |-> ##[1:3] (!O_RDATA_OE && !O_OUTPUT_VALID_N_OE))
      else $error("deselected device still drives the read side");

   cover property ($fell(O_QUEUE_FULL_N));
   cover property ($rose(O_OUTPUT_VALID_N));
   cover property (I_RD_QSEL && I_RD_QDEV != I_DEVICE_SELECT_CODE);
endmodule

bind mqs_core mqs_core_props #(.DW(DW)) u_props (
   .I_CLK(I_CLK), .I_NRST(I_NRST), .I_DEVICE_SELECT_CODE(I_DEVICE_SELECT_CODE),
   .I_SERIAL_ENABLE_IN_N(I_SERIAL_ENABLE_IN_N),
   .O_PROGRAMMING_DONE_OUT_N(O_PROGRAMMING_DONE_OUT_N), .I_WR_QSEL(I_WR_QSEL),
   .I_WR_QDEV(I_WR_QDEV), .I_WEN_N(I_WEN_N), .O_QUEUE_FULL_N(O_QUEUE_FULL_N),
   .O_QUEUE_FULL_N_OE(O_QUEUE_FULL_N_OE), .I_RD_QSEL(I_RD_QSEL), .I_RD_QDEV(I_RD_QDEV),
   .I_REN_N(I_REN_N), .I_OE_N(I_OE_N), .O_RDATA(O_RDATA), .O_RDATA_OE(O_RDATA_OE),
   .O_OUTPUT_VALID_N(O_OUTPUT_VALID_N), .O_OUTPUT_VALID_N_OE(O_OUTPUT_VALID_N_OE)
);

// ### dv/mqs_ctl_model.sv
`timescale 1ns/1ps
// Controller that owns the write and read ports; it loads nothing serially.
module mqs_ctl_model
   import mqs_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_done_n,
   output logic                   o_wr_qsel,
   output logic [DEV_W-1:0]       o_wr_qdev,
   output logic [2:0]             o_wr_qnum,
   output logic                   o_wen_n,
   output logic [DATA_W-1:0]      o_wdata,
   output logic                   o_rd_qsel,
   output logic [DEV_W-1:0]       o_rd_qdev,
   output logic [2:0]             o_rd_qnum,
   output logic                   o_rd_null,
   output logic                   o_ren_n
);
   // Idle levels; the write select fields and the read queue number carry junk between pulses so nothing leans on them.
   initial begin
      o_wr_qsel = 1'b0;
      o_wr_qdev = '0;
      o_wr_qnum = 3'h0;
      o_wen_n   = 1'b1;
      o_wdata   = '0;
      o_rd_qsel = 1'b0;
      o_rd_qdev = '0;
      o_rd_qnum = 3'h0;
      o_rd_null = 1'b0;
      o_ren_n   = 1'b1;
   end

   // Write queue select pulse, held until the edge that takes it.
   task automatic wsel(input logic [DEV_W-1:0] d, input logic [2:0] q);
      wait (i_done_n === 1'b0);
      @(posedge i_clk);
      o_wr_qsel <= 1'b1;
      o_wr_qdev <= d;
      o_wr_qnum <= q;
      @(posedge i_clk);
      o_wr_qsel <= 1'b0;
      o_wr_qdev <= ~d;
      o_wr_qnum <= ~q;
   endtask

   // Read queue select pulse; the null flag picks the always-empty queue.
   task automatic rsel(input logic [DEV_W-1:0] d, input logic [2:0] q, input logic nul);
      wait (i_done_n === 1'b0);
      @(posedge i_clk);
      o_rd_qsel <= 1'b1;
      o_rd_qdev <= d;
      o_rd_qnum <= q;
      o_rd_null <= nul;
      @(posedge i_clk);
      o_rd_qsel <= 1'b0;
      o_rd_qnum <= ~q;
   endtask

   // Back-to-back writes of counting words starting at base.
   task automatic push(input int cnt, input logic [DATA_W-1:0] base);
      @(posedge i_clk);
      o_wen_n <= 1'b0;
      for (int i = 0; i < cnt; i++) begin
         o_wdata <= DATA_W'(base + i);
         @(posedge i_clk);
      end
      o_wen_n <= 1'b1;
      o_wdata <= ~o_wdata;
   endtask

   // Read enable level, changed just after an edge.
   task automatic ren(input logic b);
      @(posedge i_clk);
      o_ren_n <= b;
   endtask
endmodule

// ### dv/mqs_core_tb.sv
`timescale 1ns/1ps
// Bench for the queue select and flag block driven through the controller model.
module mqs_core_tb
   import mqs_pkg::*;
;
   logic              clk, nrst, psel, penable, pwrite, oe_n, pready, pslverr, se, done_n;
   logic              wqs, wen_n, rqs, rnul, ren_n, full_n, full_oe, af_n, af_oe;
   logic              rd_oe, ov_n, ov_oe;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [DEV_W-1:0]  wdev, rdev;
   logic [2:0]        wq, rq;
   logic [DATA_W-1:0] wdata, rdata;
   int                err_total, n_tests, n;

   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   mqs_ctl_model ctl (.i_clk(clk), .i_done_n(done_n), .o_wr_qsel(wqs), .o_wr_qdev(wdev),
      .o_wr_qnum(wq), .o_wen_n(wen_n), .o_wdata(wdata), .o_rd_qsel(rqs), .o_rd_qdev(rdev),
      .o_rd_qnum(rq), .o_rd_null(rnul), .o_ren_n(ren_n));

   // Single device: identity and chain input tied low.
   mqs_core dut (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DEVICE_SELECT_CODE(3'h0),
      .I_SERIAL_ENABLE_IN_N(1'b0), .O_PROGRAMMING_DONE_OUT_N(done_n), .I_WR_QSEL(wqs),
      .I_WR_QDEV(wdev), .I_WR_QNUM(wq), .I_WEN_N(wen_n), .I_WDATA(wdata),
      .O_QUEUE_FULL_N(full_n), .O_QUEUE_FULL_N_OE(full_oe), .O_ALMOST_FULL_N(af_n),
      .O_ALMOST_FULL_N_OE(af_oe), .I_RD_QSEL(rqs), .I_RD_QDEV(rdev), .I_RD_QNUM(rq),
      .I_RD_NULL(rnul), .I_REN_N(ren_n), .I_OE_N(oe_n), .O_RDATA(rdata),
      .O_RDATA_OE(rd_oe), .O_OUTPUT_VALID_N(ov_n), .O_OUTPUT_VALID_N_OE(ov_oe));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Compare and count; an unknown never matches.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the idle edge first keeps two transfers from colliding.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Wait settled edges until a flag reaches a level, at most eight.
   task automatic wait_lvl(ref logic f, input logic v);
      n = 0;
      while (f !== v && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic t_prog();
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (done_n === 1'b1 && n < 40);
      chk(n, 32'(PROG_CYCLES) + 32'h2);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[ST_OWN_DONE], 1'b1);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, {24'h0, AF_OFF_RESET});
      apb(1'b0, 8'h0c, 32'h0);
      chk({31'h0, se}, 32'h1);
      chk(rd, 32'h0);
      $display("test prog done");
   endtask

   task automatic t_fill();
      ctl.wsel(3'h0, 3'h2);
      @(posedge clk);
      ctl.push(15, 18'h200);
      #1;
      chk(full_n, 1'b1);
      ctl.push(3, 18'h20f);
      #1;
      chk(full_n, 1'b0);
      apb(1'b1, REG_CTRL, 32'h0002_0002);
      apb(1'b0, REG_LEVEL, 32'h0);
      chk(rd, 32'h10);
      ctl.wsel(3'h0, 3'h3);
      for (int i = 0; i < 4; i++) begin
         #1;
         chk(full_n, i == 3);
         chk(af_n, i == 3);
         @(posedge clk);
      end
      ctl.wsel(3'h0, 3'h2);
      repeat (3) @(posedge clk);
      #1;
      chk(full_n, 1'b0);
      $display("test fill done");
   endtask

   task automatic t_read();
      ctl.rsel(3'h0, 3'h2, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      chk(rdata, 18'h200);
      chk(ov_n, 1'b0);
      wait_lvl(full_n, 1'b1);
      chk(full_n, 1'b1);
      chk(rdata, 18'h200);
      ctl.ren(1'b0);
      for (int i = 1; i < 17; i++) begin
         @(posedge clk);
         #1;
         chk(rdata, 18'h200 + ((i < 16) ? i : 15));
         chk(ov_n, i == 16);
      end
      ctl.ren(1'b1);
      ctl.push(1, 18'h3ab);
      #1;
      wait_lvl(ov_n, 1'b0);
      chk(n, 1);
      chk(rdata, 18'h3ab);
      $display("test read done");
   endtask

   task automatic t_misc();
      @(posedge clk);
      oe_n <= 1'b1;
      #1;
      chk(rd_oe, 1'b0);
      @(posedge clk);
      oe_n <= 1'b0;
      #1;
      chk({rd_oe, rdata}, {1'b1, 18'h3ab});
      ctl.rsel(3'h0, 3'h0, 1'b1);
      repeat (3) @(posedge clk);
      #1;
      chk({ov_n, rdata}, {1'b1, 18'h3ab});
      ctl.rsel(3'h1, 3'h0, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      chk({rd_oe, ov_oe}, 2'b00);
      ctl.wsel(3'h1, 3'h3);
      repeat (2) @(posedge clk);
      #1;
      chk({full_oe, af_oe}, 2'b00);
      ctl.wsel(3'h0, 3'h2);
      #1;
      chk(full_oe, 1'b0);
      @(posedge clk);
      #1;
      chk(full_oe, 1'b0);
      @(posedge clk);
      #1;
      chk({full_oe, af_oe}, 2'b11);
      $display("test misc done");
   endtask

   // Verdict and end of run, shared by the main sequence and the watchdog.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence: reset for five cycles, then the scenarios in order.
   initial begin
      {nrst, psel, penable, pwrite, oe_n} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_total = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_prog();
      t_fill();
      t_read();
      t_misc();
      print_verdict();
   end

   // Watchdog well beyond the fewer than 150 cycles the scenarios need.
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule
